//--- wwrf_consts.vh
`ifndef WWRF_CONSTS_VH
`define WWRF_CONSTS_VH

// Register byte addresses
`define WWRF_ADDR_CTRL 8'h21
`define WWRF_ADDR_FLAGS 8'h34

// Control and status field positions
`define WWRF_BIT_IFLAG 7
`define WWRF_BIT_IEN 6
`define WWRF_BIT_PS3 5
`define WWRF_BIT_CE 4
`define WWRF_BIT_EN 3
`define WWRF_BIT_PS2 2
`define WWRF_BIT_PS1 1
`define WWRF_BIT_PS0 0

// Reset source flag positions
`define WWRF_BIT_WD_FLAG 3
`define WWRF_BIT_BO_FLAG 2
`define WWRF_BIT_PIN_FLAG 1
`define WWRF_BIT_POR_FLAG 0
`define WWRF_FLAGS_RESET 4'h1

// Change window length in system clocks
`define WWRF_CE_CYCLES 3'h4
// Highest valid prescale code
`define WWRF_PS_MAX 4'h9
// Oscillator cycles at prescale code zero
`define WWRF_BASE_CYCLES 21'h000800
// Nominal oscillator rate in kHz
`define WWRF_OSC_KHZ 128

`endif

//--- wwrf_flags.v
`timescale 1ns/1ps
`include "wwrf_consts.vh"

module wwrf_flags (
   input wire clock, // System clock
   input wire rst_n, // Power-on reset, active low
   input wire wd_event, // Watchdog reset pulse
   input wire bo_event, // Brown-out reset pulse
   input wire pin_event, // External pin reset pulse
   input wire wr, // Write to flag register
   input wire [3:0] wdata, // Written flag values
   output reg [3:0] flags // Sticky reset source flags
);

   reg [3:0] next_flags;
   reg [3:0] sets;

   always @* begin
      sets = 4'h0;
      sets[`WWRF_BIT_WD_FLAG] = wd_event;
      sets[`WWRF_BIT_BO_FLAG] = bo_event;
      sets[`WWRF_BIT_PIN_FLAG] = pin_event;
      // Writing one keeps a flag, zero clears it; a set in the same cycle wins
      next_flags = flags;
      if (wr) begin
         next_flags = flags & wdata;
      end
      next_flags = next_flags | sets;
   end

   always @(posedge clock) begin
      if (!rst_n) begin
         flags <= `WWRF_FLAGS_RESET;
      end else begin
         flags <= next_flags;
      end
   end

endmodule // wwrf_flags

//--- wwrf_timer.v
`timescale 1ns/1ps
`include "wwrf_consts.vh"

module wwrf_timer #(
   parameter [20:0] BASE_CYCLES = `WWRF_BASE_CYCLES
) (
   input wire clock, // System clock
   input wire rst_n, // Reset, active low
   input wire run, // Timer running
   input wire restart, // Restart count from zero
   input wire tick, // One oscillator cycle elapsed
   input wire [3:0] code, // Prescale code as written
   output reg timeout // One-cycle timeout pulse
);

   reg [20:0] count;
   reg [20:0] limit;
   reg [3:0] use_code;

   always @* begin
      use_code = (code > `WWRF_PS_MAX) ? `WWRF_PS_MAX : code;
      limit = BASE_CYCLES << use_code;
   end

   always @(posedge clock) begin
      if (!rst_n) begin
         count <= 21'h000000;
         timeout <= 1'b0;
      end else begin
         timeout <= 1'b0;
         if (restart || !run) begin
            count <= 21'h000000;
         end else if (tick) begin
            if (count >= limit - 21'h000001) begin
               count <= 21'h000000;
               timeout <= 1'b1;
            end else begin
               count <= count + 21'h000001;
            end
         end
      end
   end

endmodule // wwrf_timer

//--- wwrf_top.v
// Overview of operation
// - Flag register upper four bits read zero
// - Watchdog reset sets flag bit three
// - Brown-out reset sets flag bit two
// - Pin reset sets flag bit one
// - Power-on sets bit zero, only software clears
// - Timeout with interrupt enable sets flag; ack or one clears
// - Interrupt needs flag, global enable, and enable or a held first timeout
// - Enable pair selects stop, interrupt, reset
// - Timeout with enable clears interrupt enable
// - Change enable self-clears after four clocks
// - Enable clear accepted only in window
// - Prescale change needs open change window
// - Higher safety level keeps watchdog enabled
// - Watchdog flag forces enable at lower level
// - Prescale code doubles timeout, 2K to 1024K
// - Reserved prescale codes use valid setting
// - Counter runs on 128 kHz oscillator
// - Counter restarts on kick, disable, reset
// - Reset-mode timeout gives one-clock pulse
// - Higher level reads enable as one
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "wwrf_consts.vh"

module wwrf_top #(
   parameter [20:0] BASE_CYCLES = `WWRF_BASE_CYCLES
) (
   input wire clock, // System clock, 40 MHz
   input wire rst_n, // Power-on reset, active low
   input wire chip_reset, // Other chip reset, active high level
   input wire osc_clk, // Watchdog oscillator level
   input wire [7:0] addr, // Register address
   input wire [7:0] wdata, // Register write data
   input wire wr, // Write strobe
   input wire rd, // Read strobe
   output reg [7:0] rdata, // Read data, cycle after strobe
   input wire kick, // Watchdog restart instruction pulse
   input wire safety_level_fuse, // High selects higher safety level
   input wire global_int_enable, // Processor global interrupt enable
   input wire int_ack, // Interrupt vector taken pulse
   input wire brownout_event, // Brown-out reset pulse
   input wire pin_event, // External pin reset pulse
   output reg timeout_irq, // Timeout interrupt request
   output reg watchdog_reset_pulse // One-clock watchdog reset
);

   ////////////////////////////////////////////////////////////////
   // Control state

   reg timeout_interrupt_flag;
   reg timeout_interrupt_enable;
   reg watchdog_enable;
   reg [3:0] timeout_prescale_select;
   reg [2:0] ce_count;
   reg osc_prev;
   reg next_flag;
   reg next_ien;
   reg next_en;
   reg [3:0] next_ps;
   reg [2:0] next_ce;
   reg irq_held;
   reg next_held;
   wire [3:0] flags;
   wire timeout;
   wire ctrl_wr;
   wire flags_wr;
   wire protected_change_enable;
   wire enable_eff;
   wire running;
   wire tick;
   wire wd_fire;
   wire local_reset_n;
   wire [7:0] ctrl_view;

   assign ctrl_wr = wr && (addr == `WWRF_ADDR_CTRL);
   assign flags_wr = wr && (addr == `WWRF_ADDR_FLAGS);
   assign protected_change_enable = (ce_count != 3'h0);

   assign enable_eff = watchdog_enable || safety_level_fuse || flags[`WWRF_BIT_WD_FLAG];

   assign running = enable_eff || timeout_interrupt_enable;

   assign wd_fire = timeout && enable_eff && !timeout_interrupt_enable;

   // Chip reset restarts control state and timer; sticky flags, output registers and osc_prev see rst_n only
   assign local_reset_n = rst_n && !chip_reset;

   // Oscillator edge to one tick
   // Oscillator is much slower than the clock, so each rising edge is one tick
   assign tick = osc_clk && !osc_prev;

   always @(posedge clock) begin
      if (!rst_n) begin
         osc_prev <= 1'b0;
      end else begin
         osc_prev <= osc_clk;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Register writes and hardware updates

   always @* begin
      next_flag = timeout_interrupt_flag;
      next_ien = timeout_interrupt_enable;
      next_en = watchdog_enable;
      next_ps = timeout_prescale_select;
      next_ce = ce_count;
      next_held = irq_held;
      if (ce_count != 3'h0) begin
         next_ce = ce_count - 3'h1;
      end
      if (int_ack) begin
         next_flag = 1'b0;
         next_held = 1'b0;
      end
      if (ctrl_wr) begin
         if (wdata[`WWRF_BIT_IFLAG]) begin
            next_flag = 1'b0;
            next_held = 1'b0;
         end
         next_ien = wdata[`WWRF_BIT_IEN];
         // Enable may always be set; clearing needs the window
         // Clear only in window
         if (wdata[`WWRF_BIT_EN] || protected_change_enable) begin
            next_en = wdata[`WWRF_BIT_EN];
         end
         if (protected_change_enable) begin
            next_ps = {wdata[`WWRF_BIT_PS3], wdata[`WWRF_BIT_PS2], wdata[`WWRF_BIT_PS1], wdata[`WWRF_BIT_PS0]};
         end
         if (wdata[`WWRF_BIT_CE] && wdata[`WWRF_BIT_EN]) begin
            next_ce = `WWRF_CE_CYCLES;
         end else if (!wdata[`WWRF_BIT_CE]) begin
            next_ce = 3'h0;
         end
      end
      if (timeout) begin
         if (timeout_interrupt_enable) begin
            next_flag = 1'b1;
         end
         if (enable_eff) begin
            next_ien = 1'b0;
         end
         // Both set: first timeout interrupts
         // The enable dropped by this timeout still gates its own flag
         if (enable_eff && timeout_interrupt_enable) begin
            next_held = 1'b1;
         end
      end
   end

   always @(posedge clock) begin
      if (!local_reset_n) begin
         timeout_interrupt_flag <= 1'b0;
         timeout_interrupt_enable <= 1'b0;
         watchdog_enable <= 1'b0;
         timeout_prescale_select <= 4'h0;
         ce_count <= 3'h0;
         irq_held <= 1'b0;
      end else begin
         timeout_interrupt_flag <= next_flag;
         timeout_interrupt_enable <= next_ien;
         watchdog_enable <= next_en;
         timeout_prescale_select <= next_ps;
         ce_count <= next_ce;
         irq_held <= next_held;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Timeout counter and reset flags

   wwrf_timer #(
      .BASE_CYCLES(BASE_CYCLES)
   ) u_timer (
      .clock(clock),
      .rst_n(local_reset_n),
      .run(running),
      .restart(kick),
      .tick(tick),
      .code(timeout_prescale_select),
      .timeout(timeout)
   );

   wwrf_flags u_flags (
      .clock(clock),
      .rst_n(rst_n),
      .wd_event(wd_fire),
      .bo_event(brownout_event),
      .pin_event(pin_event),
      .wr(flags_wr),
      .wdata(wdata[3:0]),
      .flags(flags)
   );

   ////////////////////////////////////////////////////////////////
   // Outputs and read path

   assign ctrl_view = {timeout_interrupt_flag, timeout_interrupt_enable, timeout_prescale_select[3],
      protected_change_enable, enable_eff, timeout_prescale_select[2:0]};

   always @(posedge clock) begin
      if (!rst_n) begin
         rdata <= 8'h00;
         timeout_irq <= 1'b0;
         watchdog_reset_pulse <= 1'b0;
      end else begin
         timeout_irq <= timeout_interrupt_flag && (timeout_interrupt_enable || irq_held) && global_int_enable;
         watchdog_reset_pulse <= wd_fire;
         rdata <= 8'h00;
         if (rd && addr == `WWRF_ADDR_CTRL) begin
            rdata <= ctrl_view;
         end else if (rd && addr == `WWRF_ADDR_FLAGS) begin
            rdata <= {4'h0, flags};
         end
      end
   end

endmodule // wwrf_top

//--- wwrf_checker_sva.sv
`timescale 1ns/1ps
module wwrf_checker #(
   parameter [20:0] BASE_CYCLES = 21'h000800
) (
   input wire clock, // System clock
   input wire rst_n, // Reset, active low
   input wire chip_reset, // Other reset
   input wire [7:0] addr, // Address
   input wire [7:0] wdata, // Write data
   input wire wr, // Write strobe
   input wire rd, // Read strobe
   input wire [7:0] rdata, // Read data
   input wire safety_level_fuse, // Safety level
   input wire global_int_enable, // Global enable
   input wire timeout_irq, // Interrupt
   input wire watchdog_reset_pulse // Reset pulse
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Write that opens the change window
   sequence s_open;
      wr && addr == 8'h21 && wdata[4:3] == 2'b11 && !chip_reset;
   endsequence
   AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("rdata not zero without read");
   AST_UNMAPPED: assert property ($past(rd) && $past(addr) != 8'h21 && $past(addr) != 8'h34 |-> rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_FLAGS_UPPER: assert property ($past(rd) && $past(addr) == 8'h34 |-> rdata[7:4] == 4'h0)
      else $error("flag upper bits not zero");
   AST_WD_FLAG: assert property ((watchdog_reset_pulse && !wr) ##1 (rd && addr == 8'h34) |=> rdata[3])
      else $error("watchdog flag not set");
   AST_IRQ_GATE: assert property (timeout_irq |-> $past(global_int_enable))
      else $error("irq without global enable");
   AST_CE_OPEN: assert property (s_open ##1 (!wr && !chip_reset) ##1 (rd && addr == 8'h21) |=> rdata[4])
      else $error("change window not open");
   AST_CE_CLOSE: assert property (s_open ##1 (!(wr && addr == 8'h21))[*4] ##1 (rd && addr == 8'h21) |=> !rdata[4])
      else $error("change window not closed");
   AST_PULSE_ONE: assert property (watchdog_reset_pulse |=> !watchdog_reset_pulse)
      else $error("reset pulse too long");
   AST_FUSE_EN: assert property ($past(rd) && $past(addr) == 8'h21 && $past(safety_level_fuse) |-> rdata[3])
      else $error("enable not one at higher level");
   cover property (watchdog_reset_pulse);
   cover property (timeout_irq);
   cover property (s_open ##1 !wr ##1 (rd && addr == 8'h21));
endmodule // wwrf_checker

bind wwrf_top wwrf_checker #(.BASE_CYCLES(BASE_CYCLES)) u_chk (.clock(clock), .rst_n(rst_n),
   .chip_reset(chip_reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .safety_level_fuse(safety_level_fuse), .global_int_enable(global_int_enable),
   .timeout_irq(timeout_irq), .watchdog_reset_pulse(watchdog_reset_pulse));

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic clock = 0, rst_n = 0, chip_reset = 0, osc_clk = 0, wr = 0, rd = 0, kick = 0, int_ack = 0;
   logic safety_level_fuse = 0, global_int_enable = 0, brownout_event = 0, pin_event = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, w;
   logic [1:0] div = 2'b00;
   wire [7:0] rdata;
   wire timeout_irq, watchdog_reset_pulse;
   int err_count = 0, tests_run = 0, pulses = 0, p0;

   // Short base count: timeout is 4 << code ticks
   wwrf_top #(.BASE_CYCLES(21'd4)) u_wwrf_top (.clock(clock), .rst_n(rst_n), .chip_reset(chip_reset),
      .osc_clk(osc_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .kick(kick),
      .safety_level_fuse(safety_level_fuse), .global_int_enable(global_int_enable), .int_ack(int_ack),
      .brownout_event(brownout_event), .pin_event(pin_event), .timeout_irq(timeout_irq),
      .watchdog_reset_pulse(watchdog_reset_pulse));

   initial forever #12.5 clock = ~clock;
   // One oscillator tick every four clocks
   always @(posedge clock) begin
      div <= div + 2'd1;
      osc_clk <= div[1];
   end
   always @(negedge clock) if (watchdog_reset_pulse === 1'b1) pulses++;
   ////////////////////////////////////////
   task cmp8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t read %h expected %h", $time, got, exp);
      end
   endtask
   task cmp1(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock); wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge clock); wr <= 1'b0;
   endtask
   task rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock); rd <= 1'b1; addr <= a;
      @(posedge clock); rd <= 1'b0;
      #1 cmp8(rdata, exp);
   endtask
   // Bounded wait for irq (1) or reset pulse (0)
   task wait_hi(input bit irq);
      int n;
      n = 0;
      do begin
         @(posedge clock);
         #1 n++;
      end while ((irq ? timeout_irq : watchdog_reset_pulse) !== 1'b1 && n < 60);
      cmp1(n < 60, 1'b1);
   endtask
   // Clocks between reset pulses: 4 clocks a tick, 4 << code ticks
   function automatic int exp_period(input logic [3:0] code);
      return 16 << ((code > 4'h9) ? 4'h9 : code);
   endfunction
   // Wait for one reset pulse, then count clocks to the next
   task cmp_period(input logic [3:0] code);
      int n, k;
      n = 0;
      for (k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge clock);
            #1 n++;
         end while (watchdog_reset_pulse !== 1'b1 && n < 2 * exp_period(code));
      end
      tests_run++;
      if (n != exp_period(code)) begin
         err_count++;
         $display("MISMATCH %0t period %0d expected %0d", $time, n, exp_period(code));
      end
   endtask
   task done(input string s);
      $display("test %s done", s);
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      // Tests take about 17k clocks, the reserved-code period dominating
      repeat (24000) @(posedge clock);
      err_count++;
      stop_test;
   end

   initial begin
      w = 8'($urandom(32'h91fa));
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rchk(8'h21, 8'h00);
      rchk(8'h34, 8'h01);
      @(posedge clock); brownout_event <= 1'b1; pin_event <= 1'b1;
      @(posedge clock); brownout_event <= 1'b0; pin_event <= 1'b0;
      rchk(8'h34, 8'h07);
      w = 8'($urandom);
      wreg(8'h34, w);
      rchk(8'h34, {4'h0, w[3:0] & 4'h7});
      wreg(8'h34, 8'h00);
      rchk(8'h34, 8'h00);
      wreg({2'b10, w[5:0]}, w);
      rchk({2'b01, w[5:0]}, 8'h00);
      done("flags");
      wreg(8'h21, 8'h08);
      wreg(8'h21, 8'h01);
      rchk(8'h21, 8'h08);
      wreg(8'h21, 8'h18);
      wreg(8'h21, 8'h05);
      rchk(8'h21, 8'h05);
      wreg(8'h21, 8'h1d);
      repeat (3) @(posedge clock);
      rchk(8'h21, 8'h0d);
      wreg(8'h21, 8'h00);
      rchk(8'h21, 8'h0d);
      wreg(8'h21, 8'h18);
      wreg(8'h21, 8'h00);
      done("window");
      @(posedge clock); global_int_enable <= 1'b1;
      wreg(8'h21, 8'h40);
      wait_hi(1'b1);
      rchk(8'h21, 8'hc0);
      @(posedge clock); int_ack <= 1'b1;
      @(posedge clock); int_ack <= 1'b0;
      repeat (2) @(posedge clock);
      #1 cmp1(timeout_irq, 1'b0);
      @(posedge clock); global_int_enable <= 1'b0;
      repeat (22) @(posedge clock);
      #1 cmp1(timeout_irq, 1'b0);
      rchk(8'h21, 8'hc0);
      wreg(8'h21, 8'h80);
      rchk(8'h21, 8'h00);
      done("interrupt");
      @(posedge clock); global_int_enable <= 1'b1;
      wreg(8'h21, 8'h48);
      wait_hi(1'b1);
      rchk(8'h21, 8'h88);
      wreg(8'h21, 8'h88);
      p0 = pulses;
      repeat (8) begin
         @(posedge clock); kick <= 1'b1;
         @(posedge clock); kick <= 1'b0;
         repeat (6) @(posedge clock);
      end
      cmp8(8'(pulses - p0), 8'h00);
      wait_hi(1'b0);
      rchk(8'h34, 8'h08);
      @(posedge clock); kick <= 1'b1;
      @(posedge clock); kick <= 1'b0;
      wreg(8'h21, 8'h18);
      wreg(8'h21, 8'h00);
      rchk(8'h21, 8'h08);
      wreg(8'h34, 8'h00);
      wreg(8'h21, 8'h18);
      wreg(8'h21, 8'h00);
      rchk(8'h21, 8'h00);
      done("reset mode");
      @(posedge clock); safety_level_fuse <= 1'b1; kick <= 1'b1;
      @(posedge clock); kick <= 1'b0;
      rchk(8'h21, 8'h08);
      wreg(8'h21, 8'h18);
      rchk(8'h21, 8'h18);
      wreg(8'h21, 8'h03);
      rchk(8'h21, 8'h0b);
      cmp_period(4'h3);
      wreg(8'h21, 8'h18);
      w = {2'b00, 1'b1, 2'b00, 3'h2 + 3'($urandom % 6)};
      wreg(8'h21, w);
      cmp_period({w[5], w[2:0]});
      done("fuse");
      @(posedge clock); safety_level_fuse <= 1'b0; chip_reset <= 1'b1;
      @(posedge clock); chip_reset <= 1'b0;
      rchk(8'h21, 8'h08);
      rchk(8'h34, 8'h08);
      done("chip reset");
      stop_test;
   end
endmodule // tb_top
